// [testbench/asu_mem_model.sv]
// holds a one-byte data memory model on the far side of the subtract unit
// assumes the write strobe is a one-cycle pulse on the core clock
module asu_mem_model (
  input  wire logic       i_ref_clk,
  input  wire logic       i_mem_we,
  input  wire logic [7:0] i_mem_wdata,
  output logic      [7:0] o_mem_byte
);
  timeunit 1ns;
  timeprecision 1ns;
  // a write lands at the edge that samples the strobe, no delay
  always_ff @(posedge i_ref_clk) begin
    if (i_mem_we) begin
      o_mem_byte <= i_mem_wdata;
    end
  end
endmodule

// [testbench/tb_top.sv]
// holds the self-checking bench of the subtract unit
// assumes one op per request and results one cycle after the taking edge
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic                   ref_clk, rstn, req_valid, acc_load, mem_we, done;
  logic [7:0]             acc_load_data, acc, mem_wdata, mem_byte;
  asu_pkg::asu_req_type   req;
  asu_pkg::asu_flags_type flags;
  int                     failures, n_compared;
  logic [11:0]            r;

  asu_top i_asu_top (.i_ref_clk(ref_clk), .i_rstn(rstn),
    .i_req_valid(req_valid), .i_req(req), .i_acc_load(acc_load),
    .i_acc_load_data(acc_load_data), .o_acc(acc), .o_flags(flags),
    .o_mem_we(mem_we), .o_mem_wdata(mem_wdata), .o_done(done));
  asu_mem_model i_asu_mem_model (.i_ref_clk(ref_clk), .i_mem_we(mem_we),
    .i_mem_wdata(mem_wdata), .o_mem_byte(mem_byte));

  // ****************************************
  // helpers; issue and load drive on the falling edge
  // ****************************************
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // expected {wrap, zero, half_borrow, borrow, difference}
  function automatic logic [11:0] ref_sub(logic [7:0] a, logic [7:0] b);
    logic [7:0] d;
    int         sd;
    d = a - b;
    sd = int'($signed(a)) - int'($signed(b));
    return {(sd > 127) || (sd < -128), d == 8'h00,
            a[3:0] >= b[3:0], a >= b, d};
  endfunction
  // request stays up so two calls in a row are back to back
  task automatic issue(input logic [1:0] op, input logic [7:0] m, x);
    req_valid = 1'b1;
    req = {op, m, x};
    @(negedge ref_clk);
  endtask
  task automatic load(input logic [7:0] v);
    req_valid = 1'b0;
    acc_load = 1'b1;
    acc_load_data = v;
    @(negedge ref_clk);
    acc_load = 1'b0;
  endtask
  task automatic end_sim;
    $display("compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic test_acc_mem;
    logic [15:0] pairs [5] = '{16'h0305, 16'h0505, 16'h8001, 16'h7fff,
                               16'h1001};
    foreach (pairs[i]) begin
      load(pairs[i][15:8]);
      issue(2'b00, pairs[i][7:0], 8'hff);
      r = ref_sub(pairs[i][15:8], pairs[i][7:0]);
      check(acc, r[7:0]);
      check({4'h0, flags}, {4'h0, r[11:8]});
      check({6'h00, done, mem_we}, 8'h02);
    end
    $display("test acc_mem finished");
  endtask
  task automatic test_mem;
    load(8'h03);
    issue(2'b01, 8'h05, 8'h00);
    req_valid = 1'b0;
    check({mem_we, done, acc}, {2'b11, 8'h03});
    check(mem_wdata, 8'hfe);
    check({4'h0, flags}, 8'h00);
    @(negedge ref_clk);
    check({6'h00, mem_we, done}, 8'h00);
    check(mem_byte, 8'hfe);
    $display("test mem finished");
  endtask
  task automatic test_imm_refused;
    load(8'h20);
    issue(2'b10, 8'haa, 8'h05);
    check(acc, 8'h1b);
    issue(2'b10, 8'haa, 8'h30);
    r = ref_sub(8'h1b, 8'h30);
    check({flags, acc}, r);
    acc_load = 1'b1;
    acc_load_data = 8'h77;
    issue(2'b11, 8'h01, 8'h01);
    req_valid = 1'b0;
    acc_load = 1'b0;
    check({flags, acc}, r);
    check({7'h00, done}, 8'h00);
    $display("test imm_refused finished");
  endtask
  // mid-run reset, then a request at the first edge after release
  task automatic test_reset;
    @(negedge ref_clk);
    load(8'h5a);
    rstn = 1'b0;
    repeat (2) @(negedge ref_clk);
    rstn = 1'b1;
    check({done, mem_we, mem_wdata, flags, acc}, 24'h00_0000);
    issue(2'b10, 8'h00, 8'h01);
    req_valid = 1'b0;
    check({flags, acc}, 12'h0ff);
    $display("test reset finished");
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  // safety net against a hang
  initial begin
    #100us;
    failures++;
    end_sim();
  end
  initial begin
    {rstn, req_valid, acc_load, acc_load_data, req} = '0;
    failures = 0;
    n_compared = 0;
    repeat (5) @(negedge ref_clk);
    rstn = 1'b1;
    check({flags, acc}, 12'h000);
    test_acc_mem();
    test_mem();
    test_imm_refused();
    test_reset();
    end_sim();
  end
endmodule

// [verilog/asu_pkg.sv]
// holds the shared types, op codes, flag layout and reset values
// assumes a single core clock and a decoder that issues one op per request
// Function
// - subtract-from-memory op: accumulator minus memory byte goes to accumulator
// - minus_into_memory op: difference goes to memory, accumulator unchanged
// - immediate op: accumulator minus instruction constant goes to accumulator
// - a borrow (negative difference) clears the borrow flag to zero
// - no borrow (zero or positive difference) sets the borrow flag to one
package asu_pkg;

  // ***************************************************************
  // operation codes
  // ***************************************************************
  typedef enum logic [1:0] {
    ASU_OP_ACC_MEM = 2'b00,    // acc <- acc - mem
    ASU_OP_MEM_MEM = 2'b01,    // minus_into_memory: mem <- acc - mem
    ASU_OP_ACC_IMM = 2'b10     // acc <- acc - immediate
  } asu_op_type;

  // ***************************************************************
  // status flags carried as one group
  // ***************************************************************
  typedef struct packed {
    logic signed_wrap_flag;
    logic zero_flag;
    logic half_borrow_flag;
    logic borrow_flag;       // high means no borrow
  } asu_flags_type;

  // request from decoder
  typedef struct packed {
    asu_op_type op;
    logic [7:0] mem_data;
    logic [7:0] imm_data;
  } asu_req_type;

  localparam int unsigned ASU_DATA_W   = 8;
  localparam int unsigned ASU_NIBBLE_W = 4;
  localparam logic [7:0]  ASU_ACC_RST  = 8'h00;
  localparam logic [7:0]  ASU_WDATA_RST = 8'h00;
  localparam asu_flags_type ASU_FLAGS_RST = 4'h0;

endpackage

// [verilog/asu_sub_core.sv]
// holds the combinational 8-bit subtractor and its flag derivation
// assumes operands are stable within the cycle they are presented
module asu_sub_core #(
  parameter int unsigned DATA_W = asu_pkg::ASU_DATA_W
) (
  input  wire logic [DATA_W-1:0]   i_minuend,
  input  wire logic [DATA_W-1:0]   i_subtrahend,
  output logic      [DATA_W-1:0]   o_diff,
  output asu_pkg::asu_flags_type   o_flags
);

  localparam int unsigned NW = asu_pkg::ASU_NIBBLE_W;

  logic [DATA_W:0] full_diff;
  logic [NW:0]     low_diff;

  // one extra bit catches the borrow out of each width
  always_comb begin
    full_diff = {1'b0, i_minuend} - {1'b0, i_subtrahend};
    low_diff  = {1'b0, i_minuend[NW-1:0]} - {1'b0, i_subtrahend[NW-1:0]};
    o_diff    = full_diff[DATA_W-1:0];
    // flag is inverted borrow: cleared on borrow, set otherwise
    o_flags.borrow_flag      = ~full_diff[DATA_W];
    o_flags.half_borrow_flag = ~low_diff[NW];
    o_flags.zero_flag        = (full_diff[DATA_W-1:0] == '0);
    // wrap when operand signs differ and result sign leaves minuend's
    o_flags.signed_wrap_flag =
      (i_minuend[DATA_W-1] ^ i_subtrahend[DATA_W-1]) &
      (i_minuend[DATA_W-1] ^ full_diff[DATA_W-1]);
  end

endmodule

// [verilog/asu_top.sv]
// holds the subtract unit: accumulator, flag register, memory write port
// assumes the decoder pulses i_req_valid for one cycle per instruction
// and that a request's operands settle before the edge that takes it
module asu_top #(
  parameter int unsigned DATA_W = asu_pkg::ASU_DATA_W
) (
  input  wire logic                   i_ref_clk,
  input  wire logic                   i_rstn,
  input  wire logic                   i_req_valid,
  input  wire asu_pkg::asu_req_type   i_req,
  input  wire logic                   i_acc_load,
  input  wire logic [DATA_W-1:0]      i_acc_load_data,
  output logic      [DATA_W-1:0]      o_acc,
  output asu_pkg::asu_flags_type      o_flags,
  output logic                        o_mem_we,
  output logic      [DATA_W-1:0]      o_mem_wdata,
  output logic                        o_done
);

  // ***************************************************************
  // subtractor
  // ***************************************************************
  logic [DATA_W-1:0]      sub_b;
  logic [DATA_W-1:0]      sub_diff;
  asu_pkg::asu_flags_type sub_flags;

  // immediate op takes the instruction constant as subtrahend
  always_comb begin
    if (i_req.op == asu_pkg::ASU_OP_ACC_IMM) begin
      sub_b = i_req.imm_data;
    end else begin
      sub_b = i_req.mem_data;
    end
  end

  asu_sub_core #(.DATA_W(DATA_W)) u_core (
    .i_minuend    (o_acc),
    .i_subtrahend (sub_b),
    .o_diff       (sub_diff),
    .o_flags      (sub_flags)
  );

  // ***************************************************************
  // state update
  // ***************************************************************
  logic [DATA_W-1:0]      acc_r, acc_nxt;
  asu_pkg::asu_flags_type flags_r, flags_nxt;
  logic                   we_r, we_nxt;
  logic [DATA_W-1:0]      wdata_r, wdata_nxt;
  logic                   done_r, done_nxt;

  // a subtract outranks an external accumulator load in the same cycle
  always_comb begin
    acc_nxt   = acc_r;
    flags_nxt = flags_r;
    we_nxt    = 1'b0;
    wdata_nxt = wdata_r;
    done_nxt  = 1'b0;
    if (i_req_valid) begin
      flags_nxt = sub_flags;
      done_nxt  = 1'b1;
      unique case (i_req.op)
        asu_pkg::ASU_OP_ACC_MEM: acc_nxt = sub_diff;
        asu_pkg::ASU_OP_MEM_MEM: begin
          we_nxt    = 1'b1;
          wdata_nxt = sub_diff;
        end
        asu_pkg::ASU_OP_ACC_IMM: acc_nxt = sub_diff;
        default: begin
          done_nxt  = 1'b0;      // illegal code: nothing changes
          flags_nxt = flags_r;
        end
      endcase
    end else if (i_acc_load) begin
      acc_nxt = i_acc_load_data;
    end
  end

  // registers only; synchronous active-low reset
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      acc_r   <= asu_pkg::ASU_ACC_RST;
      flags_r <= asu_pkg::ASU_FLAGS_RST;
      we_r    <= 1'b0;
      wdata_r <= asu_pkg::ASU_WDATA_RST;
      done_r  <= 1'b0;
    end else begin
      acc_r   <= acc_nxt;
      flags_r <= flags_nxt;
      we_r    <= we_nxt;
      wdata_r <= wdata_nxt;
      done_r  <= done_nxt;
    end
  end

  // ***************************************************************
  // output ports
  // ***************************************************************
  // every output is a register, so the decoder sees no glitches
  assign o_acc       = acc_r;
  assign o_flags     = flags_r;
  assign o_mem_we    = we_r;
  assign o_mem_wdata = wdata_r;
  assign o_done      = done_r;

  // ***************************************************************
  // checks
  // ***************************************************************
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn);

  // reference for the wrap flag, built apart from the core: a
  // sign-extended difference wraps when its top two bits disagree
  localparam int unsigned NW = asu_pkg::ASU_NIBBLE_W;
  logic [DATA_W:0] chk_sdiff;
  logic            chk_wrap;
  assign chk_sdiff = {o_acc[DATA_W-1], o_acc} - {sub_b[DATA_W-1], sub_b};
  assign chk_wrap  = chk_sdiff[DATA_W] ^ chk_sdiff[DATA_W-1];

  // results land exactly one cycle after the taking edge
  AST_ACC_MEM: assert property (
    i_req_valid && i_req.op == asu_pkg::ASU_OP_ACC_MEM |=>
      o_acc == DATA_W'($past(o_acc) - $past(i_req.mem_data)))
    else $error("acc minus memory result wrong");

  AST_MEM_WR: assert property (
    i_req_valid && i_req.op == asu_pkg::ASU_OP_MEM_MEM |=>
      o_mem_we && o_mem_wdata ==
      DATA_W'($past(o_acc) - $past(i_req.mem_data)))
    else $error("memory write result wrong");

  AST_MEM_ACC_KEEP: assert property (
    i_req_valid && i_req.op == asu_pkg::ASU_OP_MEM_MEM |=>
      $stable(o_acc))
    else $error("accumulator changed on memory subtract");

  AST_IMM: assert property (
    i_req_valid && i_req.op == asu_pkg::ASU_OP_ACC_IMM |=>
      o_acc == DATA_W'($past(o_acc) - $past(i_req.imm_data)))
    else $error("immediate subtract result wrong");

  // the flag reads as no-borrow, so a borrow must leave it low
  AST_BORROW_CLR: assert property (
    i_req_valid && i_req.op != 2'b11 && o_acc < sub_b |=>
      !o_flags.borrow_flag)
    else $error("borrow flag not cleared on borrow");

  AST_BORROW_SET: assert property (
    i_req_valid && i_req.op != 2'b11 && o_acc >= sub_b |=>
      o_flags.borrow_flag)
    else $error("borrow flag not set without borrow");

  AST_ZERO: assert property (
    i_req_valid && i_req.op != 2'b11 && o_acc == sub_b |=>
      o_flags.zero_flag)
    else $error("zero flag missing on equal operands");

  AST_FLAGS_HOLD: assert property (
    !i_req_valid |=> $stable(o_flags))
    else $error("flags changed without a subtract");

  AST_WE_PULSE: assert property (
    o_mem_we |=> !o_mem_we || $past(i_req_valid))
    else $error("memory write stretched");

  AST_ZERO_CLR: assert property (
    i_req_valid && i_req.op != 2'b11 && o_acc != sub_b |=>
      !o_flags.zero_flag)
    else $error("zero flag set on unequal operands");

  // half borrow looks at the low nibbles only
  AST_HALF_SET: assert property (
    i_req_valid && i_req.op != 2'b11 &&
      o_acc[NW-1:0] >= sub_b[NW-1:0] |=> o_flags.half_borrow_flag)
    else $error("half borrow flag not set without nibble borrow");

  AST_HALF_CLR: assert property (
    i_req_valid && i_req.op != 2'b11 &&
      o_acc[NW-1:0] < sub_b[NW-1:0] |=> !o_flags.half_borrow_flag)
    else $error("half borrow flag not cleared on nibble borrow");

  AST_WRAP: assert property (
    i_req_valid && i_req.op != 2'b11 |=>
      o_flags.signed_wrap_flag == $past(chk_wrap))
    else $error("signed wrap flag wrong");

  // every legal code answers exactly one cycle later
  AST_DONE: assert property (
    i_req_valid && i_req.op != 2'b11 |=> o_done)
    else $error("done pulse missing after a subtract");

  AST_IDLE: assert property (
    !i_req_valid |=> !o_done && !o_mem_we)
    else $error("done or write strobe without a request");

  // an illegal code must not even let an accumulator load through
  AST_ILLEGAL: assert property (
    i_req_valid && i_req.op == 2'b11 |=>
      $stable(o_acc) && $stable(o_flags) && !o_done && !o_mem_we)
    else $error("illegal op changed state");

  // the write strobe belongs to the memory variant alone
  AST_WE_ONLY_MEM: assert property (
    i_req_valid && i_req.op != asu_pkg::ASU_OP_MEM_MEM |=> !o_mem_we)
    else $error("memory written by an accumulator op");

  // the write port keeps its last byte until the next memory subtract
  AST_WDATA_HOLD: assert property (
    !(i_req_valid && i_req.op == asu_pkg::ASU_OP_MEM_MEM) |=>
      $stable(o_mem_wdata))
    else $error("write data changed without a memory subtract");

  // ***************************************************************
  // main scenarios
  // ***************************************************************
  COV_ACC_MEM: cover property (
    i_req_valid && i_req.op == asu_pkg::ASU_OP_ACC_MEM && o_acc < sub_b);
  COV_MEM_MEM: cover property (
    i_req_valid && i_req.op == asu_pkg::ASU_OP_MEM_MEM);
  COV_IMM_ZERO: cover property (
    i_req_valid && i_req.op == asu_pkg::ASU_OP_ACC_IMM && o_acc == sub_b);
  COV_WRAP: cover property (o_flags.signed_wrap_flag);
  COV_BACK_TO_BACK: cover property (i_req_valid ##1 i_req_valid);

endmodule
